// File: src/iopss_defines.vh
// What this block does
// RULE1: port D pins 7..4 supply: 00/01 core, 10 io rail, 11 3v3 regulator
// RULE2: port A pins 7..4 own supply selectors, same codes, reset to zero
// RULE3: any reset sets all data latches and direction bits to one
// RULE4: all pins leave reset as inputs, level set externally
// RULE5: output without prior latch write drives high from reset latch value
// RULE6: single-bit set or clear is read-modify-write of whole port byte
// RULE7: wake enable per pin on port A, per nibble on ports B to E
// RULE8: in sleep or idle, a transition on enabled pin raises wake request
// RULE9: any combination of enabled pins may wake, any one triggers
// RULE10: direction bit one is input, zero is push-pull output, bit per pin
// RULE11: reading data of an output pin returns the latch, not the pin
// RULE12: port A edge select per pin: zero rising, one falling
// RULE13: group wake bit covers one nibble, zero disables, one enables
// RULE14: decoded supply choice per pin registered, updates after a write
`ifndef IOPSS_DEFINES_VH
`define IOPSS_DEFINES_VH

// ****************************************
// geometry
// ****************************************
`define IOPSS_NPORT 5
`define IOPSS_PW 8

// ****************************************
// word indices, byte address is index times four
// ****************************************
`define IOPSS_IDX_DATA 6'h00
`define IOPSS_IDX_DIR 6'h05
`define IOPSS_IDX_EDGE 6'h0a
`define IOPSS_IDX_AWAKE 6'h0b
`define IOPSS_IDX_GWAKE 6'h0c
`define IOPSS_IDX_PA_SUP 6'h0d
`define IOPSS_IDX_PD_SUP 6'h0e
`define IOPSS_IDX_BITOP 6'h0f
`define IOPSS_IDX_IRQ_STAT 6'h10
`define IOPSS_IDX_IRQ_CLR 6'h11
`define IOPSS_IDX_IRQ_EN 6'h12

// ****************************************
// reset values and codes
// ****************************************
`define IOPSS_PORT_RST 8'hff
`define IOPSS_ZERO_RST 8'h00
`define IOPSS_SUP_IO 2'b10
`define IOPSS_SUP_3V3 2'b11

// ****************************************
// bit operation word: target, bit number, new value
// ****************************************
`define IOPSS_BOP_TGT_HI 3
`define IOPSS_BOP_TGT_LO 0
`define IOPSS_BOP_BIT_HI 6
`define IOPSS_BOP_BIT_LO 4
`define IOPSS_BOP_VAL 8
`define IOPSS_BOP_NTGT 4'ha

// ****************************************
// interrupt status bits
// ****************************************
`define IOPSS_IRQ_W 2
`define IOPSS_IRQ_WAKE 0
`define IOPSS_IRQ_BOP 1

`endif

// File: src/iopss_sync.v
`timescale 1ns/10ps
// two-flop synchroniser for the pad inputs
module iopss_sync #(
  parameter W = 40
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // pins in, synchronised out
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_q
);
  reg [W-1:0] meta_q;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      // pins idle high out of reset, so no false edge follows it
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule // iopss_sync

// File: src/iopss_top.v
`timescale 1ns/10ps
`include "iopss_defines.vh"

module iopss_top #(
  parameter PW = `IOPSS_PW,
  parameter NPORT = `IOPSS_NPORT
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // pads, port a in the low byte up to port e
  input wire [NPORT*PW-1:0] pad_in,
  output reg [NPORT*PW-1:0] pad_out_q,
  output reg [NPORT*PW-1:0] pad_oe_n_q,
  // power mode and wake
  input wire power_save,
  output reg wake_req_q,
  output reg irq_q,
  // decoded supply per pin: {3v3, io rail, core}, pins 4..7
  output reg [11:0] pa_pin_supply_q,
  output reg [11:0] pd_pin_supply_q
);

  localparam NB = NPORT * PW;
  localparam NGRP = (NPORT - 1) * 2;

  // ****************************************
  // state encoding
  // ****************************************
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ACK = 4'b0010;
  localparam [3:0] ST_RMW_RD = 4'b0100;
  localparam [3:0] ST_RMW_WR = 4'b1000;

  // ****************************************
  // functions
  // ****************************************
  // one-hot {3v3, io, core}; 00 and 01 both mean core
  function [2:0] sup_dec;
    input [1:0] code;
    begin
      if (code == `IOPSS_SUP_3V3)
        sup_dec = 3'b100;
      else if (code == `IOPSS_SUP_IO)
        sup_dec = 3'b010;
      else
        sup_dec = 3'b001;
    end
  endfunction

  function [11:0] sup_all;
    input [7:0] sel;
    begin
      sup_all = {sup_dec(sel[7:6]), sup_dec(sel[5:4]),
                 sup_dec(sel[3:2]), sup_dec(sel[1:0])};
    end
  endfunction

  // what a read of a data register shows, bit by bit
  function [7:0] port_view;
    input [7:0] latch;
    input [7:0] dir;
    input [7:0] pins;
    begin
      port_view = (dir & pins) | (~dir & latch);
    end
  endfunction

  // ****************************************
  // storage
  // ****************************************
  reg [7:0] data_q [0:NPORT-1];
  reg [7:0] dir_q [0:NPORT-1];
  reg [7:0] edge_sel_q;
  reg [7:0] pa_wake_en_q;
  reg [7:0] grp_wake_en_q;
  reg [7:0] porta_upper_supply_select_q;
  reg [7:0] portd_upper_supply_select_q;
  reg [`IOPSS_IRQ_W-1:0] irq_stat_q;
  reg [`IOPSS_IRQ_W-1:0] irq_en_q;
  reg [`IOPSS_IRQ_W-1:0] irq_stat_d;
  reg [3:0] state_q;
  reg [3:0] bop_tgt_q;
  reg [2:0] bop_bit_q;
  reg bop_val_q;
  reg [7:0] rmw_byte_q;
  reg [NB-1:0] pin_prev_q;
  wire [NB-1:0] pin_s;
  wire [5:0] idx;
  reg [31:0] rd_d;
  reg [NB-1:0] wake_hit;
  reg [7:0] rmw_new;
  integer i;

  assign idx = avs_address[7:2];

  // ****************************************
  // pad synchroniser
  // ****************************************
  iopss_sync #(
    .W(NB)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(pad_in),
    .sync_q(pin_s)
  );

  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    rd_d = 32'h0000_0000;
    for (i = 0; i < NPORT; i = i + 1) begin
      if (idx == `IOPSS_IDX_DATA + i[5:0])
        rd_d[7:0] = port_view(data_q[i], dir_q[i],
                              pin_s[i*PW +: PW]); // [RULE11]
      if (idx == `IOPSS_IDX_DIR + i[5:0])
        rd_d[7:0] = dir_q[i];
    end
    case (idx)
      `IOPSS_IDX_EDGE: rd_d[7:0] = edge_sel_q;
      `IOPSS_IDX_AWAKE: rd_d[7:0] = pa_wake_en_q;
      `IOPSS_IDX_GWAKE: rd_d[7:0] = grp_wake_en_q;
      `IOPSS_IDX_PA_SUP: rd_d[7:0] = porta_upper_supply_select_q;
      `IOPSS_IDX_PD_SUP: rd_d[7:0] = portd_upper_supply_select_q;
      `IOPSS_IDX_IRQ_STAT: rd_d[`IOPSS_IRQ_W-1:0] = irq_stat_q;
      `IOPSS_IDX_IRQ_EN: rd_d[`IOPSS_IRQ_W-1:0] = irq_en_q;
      default: rd_d[31:8] = 24'h00_0000;
    endcase
  end

  // ****************************************
  // bit operation: modify the byte fetched in the read phase
  // ****************************************
  always @* begin
    rmw_new = rmw_byte_q;
    rmw_new[bop_bit_q] = bop_val_q; // [RULE6]
  end

  // ****************************************
  // bus sequencer
  // ****************************************
  // single accesses finish one cycle after the request is seen;
  // a bit operation adds a read and a write phase before the answer
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      bop_tgt_q <= 4'h0;
      bop_bit_q <= 3'h0;
      bop_val_q <= 1'b0;
      rmw_byte_q <= `IOPSS_ZERO_RST;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (avs_write && idx == `IOPSS_IDX_BITOP) begin
            bop_tgt_q <= avs_writedata[`IOPSS_BOP_TGT_HI:`IOPSS_BOP_TGT_LO];
            bop_bit_q <= avs_writedata[`IOPSS_BOP_BIT_HI:`IOPSS_BOP_BIT_LO];
            bop_val_q <= avs_writedata[`IOPSS_BOP_VAL];
            state_q <= ST_RMW_RD;
          end else if (avs_read || avs_write) begin
            avs_readdata <= rd_d;
            avs_waitrequest <= 1'b0;
            state_q <= ST_ACK;
          end
        end
        ST_RMW_RD: begin
          // the whole byte is fetched, pins included for input bits
          rmw_byte_q <= `IOPSS_ZERO_RST;
          for (i = 0; i < NPORT; i = i + 1) begin
            if (bop_tgt_q == i[3:0])
              rmw_byte_q <= port_view(data_q[i], dir_q[i],
                                      pin_s[i*PW +: PW]); // [RULE6]
            if (bop_tgt_q == i[3:0] + NPORT[3:0])
              rmw_byte_q <= dir_q[i]; // [RULE6]
          end
          state_q <= ST_RMW_WR;
        end
        ST_RMW_WR: begin
          avs_readdata <= 32'h0000_0000;
          avs_waitrequest <= 1'b0;
          state_q <= ST_ACK;
        end
        ST_ACK: begin
          avs_waitrequest <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          avs_waitrequest <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // port registers
  // ****************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      for (i = 0; i < NPORT; i = i + 1) begin
        data_q[i] <= `IOPSS_PORT_RST; // [RULE3] [RULE5]
        dir_q[i] <= `IOPSS_PORT_RST; // [RULE3] [RULE4]
      end
      edge_sel_q <= `IOPSS_ZERO_RST;
      pa_wake_en_q <= `IOPSS_ZERO_RST;
      grp_wake_en_q <= `IOPSS_ZERO_RST;
      porta_upper_supply_select_q <= `IOPSS_ZERO_RST; // [RULE2]
      portd_upper_supply_select_q <= `IOPSS_ZERO_RST;
      irq_en_q <= {`IOPSS_IRQ_W{1'b0}};
    end else if (state_q == ST_RMW_WR) begin
      for (i = 0; i < NPORT; i = i + 1) begin
        if (bop_tgt_q == i[3:0])
          data_q[i] <= rmw_new; // [RULE6]
        if (bop_tgt_q == i[3:0] + NPORT[3:0])
          dir_q[i] <= rmw_new; // [RULE6]
      end
    end else if (state_q == ST_ACK && avs_write) begin
      for (i = 0; i < NPORT; i = i + 1) begin
        if (idx == `IOPSS_IDX_DATA + i[5:0])
          data_q[i] <= avs_writedata[7:0];
        if (idx == `IOPSS_IDX_DIR + i[5:0])
          dir_q[i] <= avs_writedata[7:0]; // [RULE10]
      end
      case (idx)
        `IOPSS_IDX_EDGE: edge_sel_q <= avs_writedata[7:0];
        `IOPSS_IDX_AWAKE: pa_wake_en_q <= avs_writedata[7:0];
        `IOPSS_IDX_GWAKE: grp_wake_en_q <= avs_writedata[7:0];
        `IOPSS_IDX_PA_SUP:
          porta_upper_supply_select_q <= avs_writedata[7:0]; // [RULE2]
        `IOPSS_IDX_PD_SUP:
          portd_upper_supply_select_q <= avs_writedata[7:0]; // [RULE1]
        `IOPSS_IDX_IRQ_EN:
          irq_en_q <= avs_writedata[`IOPSS_IRQ_W-1:0];
        default: irq_en_q <= irq_en_q;
      endcase
    end
  end

  // ****************************************
  // wake detection
  // ****************************************
  // port a picks its edge per pin; the other ports wake on either
  // edge, gated one nibble at a time
  always @* begin
    wake_hit = {NB{1'b0}};
    for (i = 0; i < PW; i = i + 1)
      wake_hit[i] = pa_wake_en_q[i] & (edge_sel_q[i] ?
                    (pin_prev_q[i] & ~pin_s[i]) :
                    (~pin_prev_q[i] & pin_s[i])); // [RULE7] [RULE12]
    for (i = PW; i < NB; i = i + 1)
      wake_hit[i] = grp_wake_en_q[(i - PW) / 4] &
                    (pin_prev_q[i] ^ pin_s[i]); // [RULE7] [RULE13]
  end

  // ****************************************
  // interrupt status, set wins over clear
  // ****************************************
  always @* begin
    irq_stat_d = irq_stat_q;
    if (state_q == ST_ACK && avs_write && idx == `IOPSS_IDX_IRQ_CLR)
      irq_stat_d = irq_stat_q & ~avs_writedata[`IOPSS_IRQ_W-1:0];
    if (power_save && (|wake_hit))
      irq_stat_d[`IOPSS_IRQ_WAKE] = 1'b1;
    if (state_q == ST_RMW_WR)
      irq_stat_d[`IOPSS_IRQ_BOP] = 1'b1;
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_prev_q <= {NB{1'b1}};
      wake_req_q <= 1'b0;
      irq_stat_q <= {`IOPSS_IRQ_W{1'b0}};
      irq_q <= 1'b0;
      pad_out_q <= {NB{1'b1}};
      pad_oe_n_q <= {NB{1'b1}}; // [RULE4]
      pa_pin_supply_q <= sup_all(`IOPSS_ZERO_RST);
      pd_pin_supply_q <= sup_all(`IOPSS_ZERO_RST);
    end else begin
      pin_prev_q <= pin_s;
      // any enabled pin, alone or with others, wakes the core
      wake_req_q <= power_save & (|wake_hit); // [RULE8] [RULE9]
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_q & irq_en_q);
      for (i = 0; i < NPORT; i = i + 1) begin
        pad_out_q[i*PW +: PW] <= data_q[i]; // [RULE5]
        pad_oe_n_q[i*PW +: PW] <= dir_q[i]; // [RULE10]
      end
      pa_pin_supply_q <= sup_all(porta_upper_supply_select_q); // [RULE14]
      pd_pin_supply_q <= sup_all(portd_upper_supply_select_q); // [RULE1]
    end
  end

endmodule // iopss_top

// File: tb/iopss_props.sv
`timescale 1ns/10ps
// ****
// port-level checks
// ****
module iopss_props #(
  parameter PW = 8,
  parameter NPORT = 5
) (
  // clock, reset, bus
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // pads, wake, supply
  input wire [NPORT*PW-1:0] pad_in,
  input wire [NPORT*PW-1:0] pad_out_q,
  input wire [NPORT*PW-1:0] pad_oe_n_q,
  input wire power_save,
  input wire wake_req_q,
  input wire irq_q,
  input wire [11:0] pa_pin_supply_q,
  input wire [11:0] pd_pin_supply_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire ack_wr = avs_write && !avs_waitrequest;
  wire [5:0] idx = avs_address[7:2];

  // one-hot {3v3, io rail, core} per pin, pin 4 lowest
  function automatic [11:0] dec(input [31:0] s);
    for (int i = 0; i < 4; i++)
      dec[3*i+:3] = s[2*i+1] ? (s[2*i] ? 3'b100 : 3'b010) : 3'b001;
  endfunction

  AST_RST_PADS: assert property (
    $rose(reset_n) |-> &pad_out_q && &pad_oe_n_q)
    else $error("pads not inputs high after reset");
  AST_RST_SUP: assert property (
    $rose(reset_n) |-> pa_pin_supply_q == 12'h249 && pd_pin_supply_q == 12'h249)
    else $error("supply outputs not core after reset");
  AST_DIR: assert property (
    ack_wr && idx == 6'h05 |->
    ##2 {24'h0, pad_oe_n_q[7:0]} == $past(avs_writedata, 2))
    else $error("direction write not on pad enables");
  AST_DATA: assert property (
    ack_wr && idx == 6'h00 |->
    ##2 {24'h0, pad_out_q[7:0]} == $past(avs_writedata, 2))
    else $error("data write not on pad outputs");
  AST_PD_SUP: assert property (
    ack_wr && idx == 6'h0e |->
    ##2 pd_pin_supply_q == dec($past(avs_writedata, 2)))
    else $error("port d supply decode wrong");
  AST_PA_SUP: assert property (
    ack_wr && idx == 6'h0d |->
    ##2 pa_pin_supply_q == dec($past(avs_writedata, 2)))
    else $error("port a supply decode wrong");
  AST_WAKE: assert property (
    wake_req_q |-> $past(power_save))
    else $error("wake request outside power save");
  AST_BITOP: assert property (
    $rose(avs_write) && idx == 6'h0f |=>
    avs_waitrequest [*2] ##1 !avs_waitrequest)
    else $error("bit operation answer timing wrong");
  AST_ACK: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
endmodule // iopss_props

bind iopss_top iopss_props #(.PW(PW), .NPORT(NPORT)) i_iopss_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
  .pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q),
  .power_save(power_save), .wake_req_q(wake_req_q), .irq_q(irq_q),
  .pa_pin_supply_q(pa_pin_supply_q), .pd_pin_supply_q(pd_pin_supply_q));

// File: tb/iopss_pins.sv
`timescale 1ns/10ps
// ****
// board circuitry on the pads
// ****
module iopss_pins #(
  parameter N = 40
) (
  // from the device
  input wire [N-1:0] pad_out_q,
  input wire [N-1:0] pad_oe_n_q,
  // level the board holds on undriven pins, pull-high by default
  input wire [N-1:0] ext_lvl,
  // to the device
  output wire [N-1:0] pad_in
);
  // a driven pin shows the device level, so no contention is modelled
  assign pad_in = (pad_oe_n_q & ext_lvl) | (~pad_oe_n_q & pad_out_q);
endmodule // iopss_pins

// File: tb/iopss_top_tb.sv
`timescale 1ns/10ps
// ****
// bench
// ****
module iopss_top_tb;
  logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic power_save, wake_req_q, irq_q;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [39:0] pad_in, pad_out_q, pad_oe_n_q, ext_lvl;
  logic [11:0] pa_pin_supply_q, pd_pin_supply_q;
  logic [2:0] dc;
  int errors, cmp_count;

  iopss_top i_iopss_top (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
    .pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q),
    .power_save(power_save), .wake_req_q(wake_req_q), .irq_q(irq_q),
    .pa_pin_supply_q(pa_pin_supply_q), .pd_pin_supply_q(pd_pin_supply_q));
  iopss_pins i_iopss_pins (.pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q),
    .ext_lvl(ext_lvl), .pad_in(pad_in));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until waitrequest is sampled low
  task bus(input logic we, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= wd;
    avs_write <= we;
    avs_read <= ~we;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) chk(40'h0, 40'h1);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task rdc(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk({8'h0, rd}, {8'h0, exp});
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // change board levels, then count wake pulses
  task wake_chk(input logic [39:0] lvl, input int exp);
    int p;
    p = 0;
    ext_lvl <= lvl;
    repeat (10) begin
      @(posedge sys_clk);
      p += wake_req_q;
    end
    chk(40'(p), 40'(exp));
  endtask

  task wrap_up;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    chk(40'h0, 40'h1);
    wrap_up;
  end

  initial begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    power_save = 1'b0;
    ext_lvl = 40'hff_ffff_ffff;
    errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    wait_n(4);
    chk(pad_oe_n_q, 40'hff_ffff_ffff);
    for (int i = 0; i < 10; i++) rdc(6'(i), 32'hff);
    rdc(6'h0d, 32'h0);
    rdc(6'h0e, 32'h0);
    wr(6'h20, 32'hff);
    rdc(6'h20, 32'h0);
    $display("test reset done");
    wr(6'h05, 32'h0);
    wait_n(2);
    chk({24'h0, pad_oe_n_q[7:0], pad_out_q[7:0]}, 40'h00ff);
    wr(6'h05, 32'hf0);
    wr(6'h00, 32'h05);
    ext_lvl <= 40'hff_ffff_ffa0;
    wait_n(4);
    rdc(6'h00, 32'ha5);
    wr(6'h0f, 32'h110);
    rdc(6'h00, 32'ha7);
    rdc(6'h10, 32'h2);
    chk({39'h0, irq_q}, 40'h0);
    wr(6'h12, 32'h2);
    wait_n(2);
    chk({39'h0, irq_q}, 40'h1);
    wr(6'h11, 32'h2);
    wait_n(2);
    chk({39'h0, irq_q}, 40'h0);
    rdc(6'h10, 32'h0);
    wr(6'h05, 32'h0);
    wait_n(2);
    chk({32'h0, pad_out_q[7:0]}, 40'ha7);
    wr(6'h0f, 32'h115);
    wait_n(2);
    chk({32'h0, pad_oe_n_q[7:0]}, 40'h02);
    wr(6'h05, 32'hff);
    ext_lvl <= 40'hff_ffff_ffff;
    $display("test bit operation done");
    for (int c = 0; c < 4; c++) begin
      dc = c[1] ? (c[0] ? 3'b100 : 3'b010) : 3'b001;
      wr(6'h0e, {24'h0, {4{c[1:0]}}});
      wait_n(2);
      chk({28'h0, pd_pin_supply_q}, {28'h0, {4{dc}}});
    end
    wr(6'h0d, 32'h1b);
    wait_n(2);
    chk({28'h0, pa_pin_supply_q}, 40'h254);
    rdc(6'h0d, 32'h1b);
    $display("test supply done");
    wr(6'h0a, 32'h01);
    wr(6'h0b, 32'h01);
    wr(6'h0c, 32'h20);
    power_save <= 1'b1;
    wake_chk(40'hff_ffff_fffe, 1);
    wake_chk(40'hff_ffff_ffff, 0);
    wake_chk(40'hff_ffff_fffd, 0);
    wake_chk(40'hff_dfff_ffff, 1);
    wake_chk(40'hff_ffff_fffe, 1);
    wake_chk(40'hfd_ffff_fffe, 0);
    power_save <= 1'b0;
    wake_chk(40'hff_dfff_ffff, 0);
    rdc(6'h10, 32'h3);
    $display("test wake done");
    wrap_up;
  end
endmodule // iopss_top_tb
